// ### tb_vcm_dyn_check.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
    err_total++; $display("mismatch %s expected %0h seen %0h", n, e, g); \
    end end
module tb_vcm_dyn_check;
    import vcm_pkg::*;
    localparam int P = 30200;
    localparam int LIMIT = 95000;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [1:0] vid_mode = 2'h1;
    logic [6:0] tgt1 = 7'h10;
    logic [6:0] tgt2 = 7'h50;
    logic [7:0] rd1 = 8'h00;
    logic [7:0] rd2 = 8'h00;
    logic [7:0] aux = 8'h21;
    logic [7:0] up = 8'h04;
    logic [7:0] lo = 8'h04;
    logic clr1 = 1'b0;
    logic clr2 = 1'b0;
    logic aux_en = 1'b1;
    logic neg_en = 1'b0;
    logic [7:0] neg_t;
    logic legacy;
    logic [5:0] vid1, vid2;
    logic six1, six2, p1, p2, f1, f2, g1, g2, alert, done, aux_v, neg_v;
    logic [7:0] aux_t;
    logic e1, e2;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;
    assign legacy = (vid_mode == 2'h0);
    vcm_vid_src i_src1 (.core_clk, .arst_n, .legacy, .target(tgt1),
        .vid(vid1), .bit_six(six1));
    vcm_vid_src i_src2 (.core_clk, .arst_n, .legacy, .target(tgt2),
        .vid(vid2), .bit_six(six2));
    vcm_dyn_check #(.PERIOD_CYCLES(P)) i_dut (.core_clk, .arst_n,
        .clk_en(1'b1), .cpu1_voltage_id_bus(vid1), .cpu2_voltage_id_bus(vid2),
        .cpu1_voltage_id_bit_six(six1), .cpu2_voltage_id_bit_six(six2),
        .cpu1_core_supply_input(rd1), .cpu2_core_supply_input(rd2),
        .auxiliary_sense_input(aux), .negative_rail_sense_input(8'h5a),
        .vid_mode, .upper_offset(up), .lower_offset(lo), .dyn_check_en(1'b1),
        .alert_en(1'b1), .cpu1_err_clear(clr1), .cpu2_err_clear(clr2),
        .aux_route_en(aux_en), .neg_route_en(neg_en), .cpu1_dyn_err_pulse(p1),
        .cpu2_dyn_err_pulse(p2), .cpu1_dyn_err_flag(f1),
        .cpu2_dyn_err_flag(f2), .cpu1_gp_input(g1), .cpu2_gp_input(g2),
        .dyn_alert(alert), .cycle_done(done), .aux_fan_temp(aux_t),
        .aux_fan_temp_valid(aux_v), .neg_fan_temp(neg_t),
        .neg_fan_temp_valid(neg_v));
    // Code voltage in whole reading steps
    function automatic logic [7:0] volt(logic [VW-1:0] base,
        logic [VW-1:0] step, logic [6:0] code);
        return 8'((base - VW'(code) * step) >> FRAC);
    endfunction : volt
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test
    // Bounded wait for the next compare, keeping its error pulses
    task automatic wait_done();
        int n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (done !== 1'b1 && n < P + 100);
        `CHK("cycle_done", 1'b1, done)
        e1 = p1;
        e2 = p2;
    endtask : wait_done
    // One reading just past the upper bound, the other right on it
    task automatic t_range();
        @(posedge core_clk);
        rd1 <= volt(BASE_EXT, STEP_EXT, 7'h10) + up + 8'h01;
        rd2 <= volt(BASE_EXT, STEP_EXT, 7'h50) + up;
        wait_done();
        `CHK("cpu1 pulse", 1'b1, e1)
        `CHK("cpu2 pulse", 1'b0, e2)
        `CHK("cpu1 flag", 1'b1, f1)
        `CHK("gp inputs", 2'h0, {g1, g2})
        @(negedge core_clk);
        `CHK("alert", 1'b1, alert)
        $display("range test finished");
    endtask : t_range
    // Off code mid-window masks cpu1 even at reading zero
    task automatic t_skip();
        @(posedge core_clk);
        clr1 <= 1'b1;
        rd1 <= 8'h00;
        rd2 <= volt(BASE_EXT, STEP_EXT, 7'h50) - lo - 8'h01;
        @(posedge core_clk);
        clr1 <= 1'b0;
        @(negedge core_clk);
        `CHK("cpu1 flag cleared", 1'b0, f1)
        repeat (10000) @(negedge core_clk);
        `CHK("aux temp", aux ^ 8'h80, aux_t)
        `CHK("aux valid", 1'b1, aux_v)
        `CHK("neg valid", 1'b0, neg_v)
        @(posedge core_clk);
        tgt1 <= 7'h3f;
        neg_en <= 1'b1;
        repeat (1000) @(negedge core_clk);
        @(posedge core_clk);
        tgt1 <= 7'h10;
        wait_done();
        `CHK("cpu1 pulse skipped", 1'b0, e1)
        `CHK("cpu2 pulse", 1'b1, e2)
        `CHK("cpu2 flag", 1'b1, f2)
        $display("skip test finished");
    endtask : t_skip
    // Legacy: pins become inputs; upper bound exactly at the ceiling
    task automatic t_legacy();
        @(posedge core_clk);
        vid_mode <= 2'h0;
        clr2 <= 1'b1;
        tgt1 <= 7'h50;
        up <= 8'(UPPER_CEIL >> FRAC) - volt(BASE_LEG, STEP_LEG, 7'h10);
        rd1 <= 8'hff;
        rd2 <= volt(BASE_LEG, STEP_LEG, 7'h10) - lo;
        @(posedge core_clk);
        clr2 <= 1'b0;
        repeat (200) @(negedge core_clk);
        `CHK("gp inputs", 2'h3, {g1, g2})
        `CHK("cpu2 flag cleared", 1'b0, f2)
        `CHK("neg temp", 8'h5a ^ 8'h80, neg_t)
        `CHK("neg valid on", 1'b1, neg_v)
        wait_done();
        `CHK("cpu1 pulse at ceiling", 1'b1, e1)
        `CHK("cpu2 pulse", 1'b0, e2)
        $display("legacy test finished");
    endtask : t_legacy
    initial forever #25 core_clk = ~core_clk;
    // Cut a hung run short
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_total++;
            end_of_test();
        end
    end
    initial begin
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        t_range();
        t_skip();
        t_legacy();
        end_of_test();
    end
endmodule : tb_vcm_dyn_check
`default_nettype wire

// ### vcm_dyn_check.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// RQ1: Each core-supply reading is checked against bounds built from its own processor's voltage code.
// RQ2: This check runs on its own and never waits on or masks the fixed-limit check.
// RQ3: A two-bit mode picks legacy, extended or one of two newer code sets. Both newer modes share one code set here.
// RQ4: The processor changes its code at most one step per 5 us in legacy mode.
// RQ5: A code is used only after it has held still for a short settle time.
// RQ6: The code voltage is averaged over a 1.5 ms window of evenly spaced samples.
// RQ7: Comparison at the end of the cycle uses the averaged voltage only.
// RQ8: Upper bound is average plus upper offset; lower is average minus lower offset.
// RQ9: A reading above the upper or below the lower bound makes an error pulse.
// RQ10: The comparison runs once every 100 ms.
// RQ11: A regulator-off code anywhere in the window skips that sample's check.
// RQ12: If average plus upper offset passes 1.5875 V only the lower check runs.
// RQ13: In legacy mode the two bit-six pins are general inputs, else code bit six.
// RQ14: Auxiliary and negative-rail readings can be routed to fan control.
// RQ15: Routed readings are returned signed by inverting the top bit.
// RQ16: Each error sets a sticky flag per processor that can drive the alert.
module vcm_dyn_check
    import vcm_pkg::*;
#(
    parameter int PERIOD_CYCLES = PERIOD_CYC
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [5:0] cpu1_voltage_id_bus,
    input wire logic [5:0] cpu2_voltage_id_bus,
    input wire logic cpu1_voltage_id_bit_six,
    input wire logic cpu2_voltage_id_bit_six,
    input wire logic [7:0] cpu1_core_supply_input,
    input wire logic [7:0] cpu2_core_supply_input,
    input wire logic [7:0] auxiliary_sense_input,
    input wire logic [7:0] negative_rail_sense_input,
    input wire logic [1:0] vid_mode,
    input wire logic [7:0] upper_offset,
    input wire logic [7:0] lower_offset,
    input wire logic dyn_check_en,
    input wire logic alert_en,
    input wire logic cpu1_err_clear,
    input wire logic cpu2_err_clear,
    input wire logic aux_route_en,
    input wire logic neg_route_en,
    output logic cpu1_dyn_err_pulse,
    output logic cpu2_dyn_err_pulse,
    output logic cpu1_dyn_err_flag,
    output logic cpu2_dyn_err_flag,
    output logic cpu1_gp_input,
    output logic cpu2_gp_input,
    output logic dyn_alert,
    output logic cycle_done,
    output logic [7:0] aux_fan_temp,
    output logic aux_fan_temp_valid,
    output logic [7:0] neg_fan_temp,
    output logic neg_fan_temp_valid
);
    // Reset release through two flops
    logic [1:0] rst_sync_q;
    wire rst_n = rst_sync_q[1];

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    // Pins from the processors come from outside the clock domain
    wire [6:0] vid_raw [2];
    assign vid_raw[0] = {cpu1_voltage_id_bit_six, cpu1_voltage_id_bus};
    assign vid_raw[1] = {cpu2_voltage_id_bit_six, cpu2_voltage_id_bus};
    wire [7:0] reading [2];
    assign reading[0] = cpu1_core_supply_input;
    assign reading[1] = cpu2_core_supply_input;
    wire err_clear [2];
    assign err_clear[0] = cpu1_err_clear;
    assign err_clear[1] = cpu2_err_clear;

    // RQ3 mode select
    wire vcm_mode_t mode = vcm_mode_t'(vid_mode);
    wire legacy = (mode == VCM_LEGACY);

    // Period timer and window launch
    logic [31:0] period_q;
    vcm_state_t state_q;
    vcm_state_t state_d;
    // RQ10 one comparison per period
    wire period_end = (period_q == 32'(PERIOD_CYCLES - 1));
    // Window is placed so that it closes shortly before the period ends
    wire win_start = (state_q == VCM_IDLE) &&
        (period_q == 32'(PERIOD_CYCLES - WIN_CYC - SKEW_CYC - 4));

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            period_q <= '0;
        end else if (clk_en) begin
            period_q <= period_end ? '0 : period_q + 32'h1;
        end
    end

    logic [1:0] done;
    logic [1:0] off_seen;
    logic [VW-1:0] avg [2];

    // Sequencer: wait, sample the window, compare once
    always_comb begin
        state_d = state_q;
        case (state_q)
            VCM_IDLE: begin
                if (win_start) begin
                    state_d = VCM_SAMPLE;
                end
            end
            VCM_SAMPLE: begin
                if (done[0]) begin
                    state_d = VCM_COMPARE;
                end
            end
            VCM_COMPARE: begin
                state_d = VCM_IDLE;
            end
            default: begin
                state_d = VCM_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= VCM_IDLE;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    // RQ7 compare strobe only after the window's mean is ready
    // RQ2 own strobe, shares nothing with any fixed-limit check
    wire compare = (state_q == VCM_COMPARE) && dyn_check_en;

    logic [1:0] err_pulse_q;
    logic [1:0] err_flag_q;
    logic [1:0] gp_q;

    // Per-processor synchroniser, averager and bound check
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        logic [6:0] vid_s1_q;
        logic [6:0] vid_s2_q;

        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                vid_s1_q <= '0;
                vid_s2_q <= '0;
            end else if (clk_en) begin
                vid_s1_q <= vid_raw[ch];
                vid_s2_q <= vid_s1_q;
            end
        end

        // RQ13 bit six only counts outside legacy mode
        wire [6:0] code = {vid_s2_q[6] && !legacy, vid_s2_q[5:0]};

        // RQ1 each averager sees its own processor's code
        vcm_vid_avg u_avg (
            .clk(core_clk),
            .rst_n(rst_n),
            .ce(clk_en),
            .vid_code(code),
            .mode(mode),
            .win_start(win_start),
            .avg_q(avg[ch]),
            .off_q(off_seen[ch]),
            .done_q(done[ch])
        );

        // RQ8 bounds from the mean plus and minus the offsets
        wire [SW-1:0] rd = SW'({reading[ch], {FRAC{1'b0}}});
        wire [SW-1:0] up = SW'(avg[ch]) + SW'({upper_offset, {FRAC{1'b0}}});
        wire [SW-1:0] lo_off = SW'({lower_offset, {FRAC{1'b0}}});
        wire lo_valid = SW'(avg[ch]) >= lo_off;
        wire [SW-1:0] lo = SW'(avg[ch]) - lo_off;
        // RQ12 upper check dropped past the ceiling
        wire up_ok = (up <= UPPER_CEIL);
        // RQ9 outside either bound
        wire over = up_ok && (rd > up);
        wire under = lo_valid && (rd < lo);
        // RQ11 skip a sample that saw the off code
        wire hit = compare && !off_seen[ch] && (over || under);

        // RQ16 sticky flag, a new error wins over a clear
        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                err_pulse_q[ch] <= 1'b0;
                err_flag_q[ch] <= 1'b0;
                gp_q[ch] <= 1'b0;
            end else if (clk_en) begin
                err_pulse_q[ch] <= hit;
                err_flag_q[ch] <= hit || (err_flag_q[ch] && !err_clear[ch]);
                // RQ13 general input level, shown only in legacy mode
                gp_q[ch] <= legacy && vid_s2_q[6];
            end
        end
    end

    assign cpu1_dyn_err_pulse = err_pulse_q[0];
    assign cpu2_dyn_err_pulse = err_pulse_q[1];
    assign cpu1_dyn_err_flag = err_flag_q[0];
    assign cpu2_dyn_err_flag = err_flag_q[1];
    assign cpu1_gp_input = gp_q[0];
    assign cpu2_gp_input = gp_q[1];

    // RQ16 alert from either flag; late by one cycle behind the flags
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dyn_alert <= 1'b0;
            cycle_done <= 1'b0;
        end else if (clk_en) begin
            dyn_alert <= alert_en && (|err_flag_q);
            cycle_done <= (state_q == VCM_COMPARE);
        end
    end

    // RQ15 signed form: invert the top bit of the conversion code
    wire [7:0] aux_signed = {~auxiliary_sense_input[7],
        auxiliary_sense_input[6:0]};
    wire [7:0] neg_signed = {~negative_rail_sense_input[7],
        negative_rail_sense_input[6:0]};

    // RQ14 routing to fan control, refreshed each period
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aux_fan_temp <= '0;
            aux_fan_temp_valid <= 1'b0;
            neg_fan_temp <= '0;
            neg_fan_temp_valid <= 1'b0;
        end else if (clk_en) begin
            aux_fan_temp_valid <= aux_route_en;
            neg_fan_temp_valid <= neg_route_en;
            if (aux_route_en && period_end) begin
                aux_fan_temp <= aux_signed;
            end
            if (neg_route_en && period_end) begin
                neg_fan_temp <= neg_signed;
            end
        end
    end
endmodule : vcm_dyn_check
`default_nettype wire

// ### vcm_dyn_check_properties.sv
`timescale 1ns/1ps
`default_nettype none
module vcm_dyn_check_properties
    import vcm_pkg::*;
#(
    parameter int PERIOD_CYCLES = PERIOD_CYC
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [1:0] vid_mode,
    input wire logic alert_en,
    input wire logic cpu1_err_clear,
    input wire logic aux_route_en,
    input wire logic neg_route_en,
    input wire logic cpu1_dyn_err_pulse,
    input wire logic cpu2_dyn_err_pulse,
    input wire logic cpu1_dyn_err_flag,
    input wire logic cpu2_dyn_err_flag,
    input wire logic cpu1_gp_input,
    input wire logic cpu2_gp_input,
    input wire logic dyn_alert,
    input wire logic cycle_done,
    input wire logic aux_fan_temp_valid,
    input wire logic neg_fan_temp_valid
);
    logic [2:0] live_q;
    logic seen_q;
    int gap_q;
    // Checks wait out the two-flop reset copy; gap spans compares
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            live_q <= 3'h0;
            seen_q <= 1'b0;
            gap_q <= 0;
        end else begin
            if (live_q != 3'h4) live_q <= live_q + 3'h1;
            seen_q <= seen_q | cycle_done;
            gap_q <= cycle_done ? 0 : gap_q + 1;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n || live_q != 3'h4);
    sequence s_hit;
        cpu1_dyn_err_pulse || cpu2_dyn_err_pulse;
    endsequence
    sequence s_nonlegacy;
        (vid_mode != 2'h0) [*3];
    endsequence
    property p_pulse_once;
        s_hit |=> !cpu1_dyn_err_pulse && !cpu2_dyn_err_pulse;
    endproperty
    a_pulse_once: assert property (p_pulse_once)
        else $error("error pulse longer than one cycle");
    property p_flag1_set;
        cpu1_dyn_err_pulse |-> cpu1_dyn_err_flag;
    endproperty
    a_flag1_set: assert property (p_flag1_set)
        else $error("cpu1 flag not set by pulse");
    property p_flag2_set;
        cpu2_dyn_err_pulse |-> cpu2_dyn_err_flag;
    endproperty
    a_flag2_set: assert property (p_flag2_set)
        else $error("cpu2 flag not set by pulse");
    property p_hit_at_done;
        s_hit |-> cycle_done;
    endproperty
    a_hit_at_done: assert property (p_hit_at_done)
        else $error("error pulse away from compare");
    property p_flag_hold;
        cpu1_dyn_err_flag && !cpu1_err_clear |=> cpu1_dyn_err_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("cpu1 flag dropped without clear");
    property p_alert_on;
        alert_en && (cpu1_dyn_err_flag || cpu2_dyn_err_flag) |=> dyn_alert;
    endproperty
    a_alert_on: assert property (p_alert_on)
        else $error("alert missing");
    property p_alert_off;
        !(cpu1_dyn_err_flag || cpu2_dyn_err_flag) |=> !dyn_alert;
    endproperty
    a_alert_off: assert property (p_alert_off)
        else $error("alert without flag");
    property p_gp_off;
        s_nonlegacy |=> !cpu1_gp_input && !cpu2_gp_input;
    endproperty
    a_gp_off: assert property (p_gp_off)
        else $error("general input shown outside legacy mode");
    property p_period;
        cycle_done && seen_q |-> gap_q == PERIOD_CYCLES - 1;
    endproperty
    a_period: assert property (p_period)
        else $error("compare spacing differs from period");
    property p_aux_valid;
        aux_route_en |=> aux_fan_temp_valid;
    endproperty
    a_aux_valid: assert property (p_aux_valid)
        else $error("aux route valid missing");
    property p_neg_valid;
        !neg_route_en |=> !neg_fan_temp_valid;
    endproperty
    a_neg_valid: assert property (p_neg_valid)
        else $error("neg route valid while off");
endmodule : vcm_dyn_check_properties
bind vcm_dyn_check vcm_dyn_check_properties #(
    .PERIOD_CYCLES(PERIOD_CYCLES)
) i_props (.core_clk, .arst_n, .vid_mode, .alert_en, .cpu1_err_clear,
    .aux_route_en, .neg_route_en, .cpu1_dyn_err_pulse, .cpu2_dyn_err_pulse,
    .cpu1_dyn_err_flag, .cpu2_dyn_err_flag, .cpu1_gp_input, .cpu2_gp_input,
    .dyn_alert, .cycle_done, .aux_fan_temp_valid, .neg_fan_temp_valid);
`default_nettype wire

// ### vcm_pkg.sv
package vcm_pkg;
    // Clock figures
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_KHZ = CLK_HZ / 1000;
    // Comparison period and averaging window, as times
    localparam int PERIOD_MS = 100;
    localparam int WIN_US = 1500;
    localparam int PERIOD_CYC = PERIOD_MS * CLK_KHZ;
    localparam int WIN_CYC = (WIN_US * CLK_KHZ) / 1000;
    // Window is taken as a fixed number of evenly spaced samples
    localparam int SAMPLE_SH = 5;
    localparam int SAMPLE_NUM = 1 << SAMPLE_SH;
    localparam int GAP_CYC = WIN_CYC / SAMPLE_NUM;
    // Least time a code must hold before it counts as settled
    localparam int SKEW_NS = 400;
    localparam int SKEW_CYC = (SKEW_NS * CLK_KHZ + 999_999) / 1_000_000;
    // Voltage units: reading LSBs with three fraction bits
    localparam int FRAC = 3;
    localparam int VW = 8 + FRAC;
    localparam int SW = VW + 1;
    localparam int ACCW = VW + SAMPLE_SH;
    // Ceiling on the upper bound, in 0.1 mV, against full scale
    localparam int CEIL_MV10 = 15875;
    localparam int FS_MV10 = 16000;
    localparam logic [SW-1:0] UPPER_CEIL =
        SW'((CEIL_MV10 * 256 * (1 << FRAC)) / FS_MV10);
    // Code-to-voltage line per mode (volt = base - code * step)
    localparam logic [VW-1:0] BASE_LEG = 11'h7f8;
    localparam logic [VW-1:0] STEP_LEG = 11'h010;
    localparam logic [VW-1:0] BASE_EXT = 11'h7f8;
    localparam logic [VW-1:0] STEP_EXT = 11'h008;
    localparam logic [VW-1:0] BASE_NEW = 11'h7f8;
    localparam logic [VW-1:0] STEP_NEW = 11'h008;
    // Codes that command the regulator off
    localparam logic [6:0] OFF_LEG = 7'h3f;
    localparam logic [6:0] OFF_NEW = 7'h00;

    typedef enum logic [1:0] {
        VCM_LEGACY = 2'h0,
        VCM_EXTENDED = 2'h1,
        VCM_NEWER = 2'h2,
        VCM_NEWER_ALT = 2'h3
    } vcm_mode_t;

    typedef enum logic [1:0] {
        VCM_IDLE = 2'h0,
        VCM_SAMPLE = 2'h1,
        VCM_COMPARE = 2'h3
    } vcm_state_t;
endpackage : vcm_pkg

// ### vcm_vid_avg.sv
`timescale 1ns/1ps
`default_nettype none
module vcm_vid_avg
    import vcm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [6:0] vid_code,
    input wire vcm_mode_t mode,
    input wire logic win_start,
    output logic [VW-1:0] avg_q,
    output logic off_q,
    output logic done_q
);
    logic [6:0] last_q;
    logic [6:0] code_q;
    logic [3:0] hold_q;
    logic [15:0] gap_q;
    logic [SAMPLE_SH:0] left_q;
    logic [ACCW-1:0] acc_q;
    logic busy_q;

    // RQ5 skew filter: a code counts only after it has held still
    wire stable = (vid_code == last_q);
    wire settled = stable && (hold_q == 4'(SKEW_CYC - 1));

    // Voltage of the settled code under the current mode
    wire legacy = (mode == VCM_LEGACY);
    wire newer = (mode == VCM_NEWER) || (mode == VCM_NEWER_ALT);
    wire [VW-1:0] base = legacy ? BASE_LEG : (newer ? BASE_NEW : BASE_EXT);
    wire [VW-1:0] step = legacy ? STEP_LEG : (newer ? STEP_NEW : STEP_EXT);
    wire [VW+6:0] drop = 18'(code_q) * 18'(step);
    wire [VW-1:0] volt = (drop > 18'(base)) ? '0 : base - VW'(drop);
    // RQ11 regulator-off code seen
    wire is_off = code_q == (newer ? OFF_NEW : OFF_LEG);
    wire take = busy_q && (gap_q == 16'(GAP_CYC - 1));
    wire last = take && (left_q == (SAMPLE_SH + 1)'(1));

    // Skew filter registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_q <= '0;
            code_q <= '0;
            hold_q <= '0;
        end else if (ce) begin
            last_q <= vid_code;
            hold_q <= (!stable) ? '0 : (settled ? hold_q : hold_q + 4'h1);
            if (settled) begin
                code_q <= vid_code;
            end
        end
    end

    // RQ6 window sampling and accumulation
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            gap_q <= '0;
            left_q <= '0;
            acc_q <= '0;
            off_q <= 1'b0;
        end else if (ce) begin
            if (win_start) begin
                busy_q <= 1'b1;
                gap_q <= '0;
                left_q <= (SAMPLE_SH + 1)'(SAMPLE_NUM);
                acc_q <= '0;
                off_q <= is_off;
            end else if (busy_q) begin
                gap_q <= take ? '0 : gap_q + 16'h1;
                // RQ11 off at any point marks the sample
                off_q <= off_q || is_off;
                if (take) begin
                    acc_q <= acc_q + ACCW'(volt);
                    left_q <= left_q - (SAMPLE_SH + 1)'(1);
                end
                if (last) begin
                    busy_q <= 1'b0;
                end
            end
        end
    end

    // RQ6 mean of the window, ready with the done pulse
    wire [ACCW-1:0] acc_fin = acc_q + ACCW'(volt);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avg_q <= '0;
            done_q <= 1'b0;
        end else if (ce) begin
            done_q <= last;
            if (last) begin
                avg_q <= VW'(acc_fin >> SAMPLE_SH);
            end
        end
    end
endmodule : vcm_vid_avg
`default_nettype wire

// ### vcm_vid_src.sv
`timescale 1ns/1ps
`default_nettype none
// Processor code source: in legacy mode walks the six-bit bus one step per change toward the target while bit six jumps to it; else jumps straight to it
module vcm_vid_src (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic legacy,
    input wire logic [6:0] target,
    output logic [5:0] vid,
    output logic bit_six
);
    logic [6:0] cur_q;
    logic [6:0] old_q;
    logic [6:0] step;
    logic [7:0] gap_q;
    logic skew_q;
    assign step[5:0] = (target[5:0] == cur_q[5:0]) ? cur_q[5:0] :
        (target[5:0] > cur_q[5:0]) ? cur_q[5:0] + 6'h1 : cur_q[5:0] - 6'h1;
    assign step[6] = target[6];
    // Lines settle a cycle apart, so a stray code shows briefly
    assign {bit_six, vid} = skew_q ? {old_q[6:3], cur_q[2:0]} : cur_q;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cur_q <= 7'h00;
            old_q <= 7'h00;
            gap_q <= 8'h00;
            skew_q <= 1'b0;
        end else if (cur_q != target && gap_q >= 8'h63) begin
            cur_q <= legacy ? step : target;
            old_q <= cur_q;
            gap_q <= 8'h00;
            skew_q <= 1'b1;
        end else begin
            gap_q <= gap_q + 8'h01;
            skew_q <= 1'b0;
        end
    end
endmodule : vcm_vid_src
`default_nettype wire
